// ---- rtl/gesb_pkg.sv ----
// constants for the general event status bank
package gesb_pkg;
  // register indices as printed, byte address is four times the index
  localparam logic [7:0] STATUS_INDEX = 8'h18;
  localparam logic [7:0] ENABLE_INDEX = 8'h1A;
  localparam logic [7:0] STATUS_ADDR = 8'(4 * STATUS_INDEX);
  localparam logic [7:0] ENABLE_ADDR = 8'(4 * ENABLE_INDEX);
  localparam logic [7:0] CONFIG_ADDR = 8'h80;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h84;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h88;

  // event status / enable bit positions
  localparam int RING_BIT = 11;
  localparam int AC_POWER_BIT = 10;
  localparam int DOCKING_BIT = 8;
  localparam int EXT_LOW_BIT = 4;
  localparam int USB_BIT = 2;
  localparam int OVERRIDE_BIT = 1;
  localparam int THERMAL_BIT = 0;
  localparam logic [15:0] IMPLEMENTED_MASK = 16'h0DF7;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] IRQ_MASK_RESET = 16'h0000;

  // configuration register fields
  localparam int POLARITY_BIT = 0;
  localparam int AUTO_THROTTLE_BIT = 1;
  localparam int SELECT_BIT = 2;
  localparam int DUTY_LOW_BIT = 3;
  localparam int DUTY_WIDTH = 3;
  localparam logic [5:0] CONFIG_RESET = 6'h00;

  // thermal alarm qualification time
  localparam int CLOCK_HZ = 100_000_000;
  localparam int ALARM_TIME_S = 2;
  localparam int ALARM_CYCLES = ALARM_TIME_S * CLOCK_HZ;
  localparam int THROTTLE_SLOT_CYCLES = 16;
  localparam int SYNC_WIDTH = 9;
  // idle pin levels: low-active ring, docking and thermal inputs rest high
  localparam logic [8:0] SYNC_RESET = 9'h105;
endpackage : gesb_pkg

// ---- rtl/gesb_event_status_bank.sv ----
// general event status and enable register bank with thermal throttling
`timescale 1ns/1ps
module gesb_event_status_bank #(
  parameter int ALARM_CYCLES = gesb_pkg::ALARM_CYCLES,
  parameter int SLOT_CYCLES = gesb_pkg::THROTTLE_SLOT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ringIndicatorN,
  input wire logic acPowerPresent,
  input wire logic dockingInsertN,
  input wire logic extInputA,
  input wire logic extInputB,
  input wire logic extInputC,
  input wire logic extInputD,
  input wire logic usbWake,
  input wire logic thermalAlarmN,
  output logic controlInterrupt,
  output logic managementInterrupt,
  output logic cpuClockRun,
  output logic throttling,
  output logic irq
);

  logic [gesb_pkg::SYNC_WIDTH-1:0] rawIn;
  logic [gesb_pkg::SYNC_WIDTH-1:0] syncFirst;
  logic [gesb_pkg::SYNC_WIDTH-1:0] syncIn;
  logic ringSync;
  logic acPowerSync;
  logic dockingSync;
  logic [3:0] extSync;
  logic usbSync;
  logic thermalSync;
  logic [3:0] extPrev;
  logic extPrevValid;
  logic [15:0] eventStatusZero;
  logic [15:0] eventEnableZero;
  logic [15:0] irqStatus;
  logic [15:0] irqMask;
  logic [5:0] cfgReg;
  logic [15:0] setVector;
  logic [15:0] next_status;
  logic [15:0] clearVector;
  logic [15:0] flagRise;
  logic anyEnabled;
  logic alarmActive;
  logic overrideEvent;
  logic [31:0] alarmCount;
  logic alarmQualified;
  logic [31:0] slotCount;
  logic [2:0] slotIndex;
  logic [2:0] duty;
  logic autoThrottle;
  logic routeControl;
  logic accessDone;
  logic accessStart;
  logic writeDone;
  logic readDone;
  logic statusWrite;
  logic enableWrite;
  logic configWrite;
  logic maskWrite;
  logic irqStatusRead;
  logic addrMapped;
  logic [15:0] readValue;

  // configuration fields
  assign duty = cfgReg[gesb_pkg::DUTY_LOW_BIT +: gesb_pkg::DUTY_WIDTH];
  assign autoThrottle = cfgReg[gesb_pkg::AUTO_THROTTLE_BIT];
  assign routeControl = cfgReg[gesb_pkg::SELECT_BIT];

  // two-stage synchroniser on every event pin
  assign rawIn = {thermalAlarmN, usbWake, extInputD, extInputC, extInputB, extInputA,
    dockingInsertN, acPowerPresent, ringIndicatorN};

  // reset to idle pin levels so no false event follows reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      syncFirst <= gesb_pkg::SYNC_RESET;
      syncIn <= gesb_pkg::SYNC_RESET;
    end else begin
      syncFirst <= rawIn;
      syncIn <= syncFirst;
    end
  end

  // synchronised pins by name
  assign ringSync = syncIn[0];
  assign acPowerSync = syncIn[1];
  assign dockingSync = syncIn[2];
  assign extSync = syncIn[6:3];
  assign usbSync = syncIn[7];
  assign thermalSync = syncIn[8];

  // previous level of the extended inputs for toggle detection
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      extPrev <= 4'h0;
      extPrevValid <= 1'b0;
    end else begin
      extPrev <= extSync;
      extPrevValid <= 1'b1;
    end
  end

  // thermal alarm level after polarity selection
  assign alarmActive = cfgReg[gesb_pkg::POLARITY_BIT] ? thermalSync : ~thermalSync;

  // alarm duration counter
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      alarmCount <= 32'h0;
    end else if (!(alarmActive && autoThrottle)) begin
      alarmCount <= 32'h0;
    end else if (alarmCount < 32'(ALARM_CYCLES)) begin
      alarmCount <= alarmCount + 32'h1;
    end
  end

  // qualified once the count has reached the limit
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      alarmQualified <= 1'b0;
    end else if (!(alarmActive && autoThrottle)) begin
      alarmQualified <= 1'b0;
    end else if (alarmCount >= 32'(ALARM_CYCLES)) begin
      alarmQualified <= 1'b1;
    end
  end

  assign overrideEvent = alarmActive && autoThrottle && !alarmQualified &&
    (alarmCount >= 32'(ALARM_CYCLES));

  // hardware set sources
  always_comb begin
    setVector = 16'h0000;
    setVector[gesb_pkg::RING_BIT] = ~ringSync;
    setVector[gesb_pkg::AC_POWER_BIT] = acPowerSync;
    setVector[gesb_pkg::DOCKING_BIT] = ~dockingSync;
    setVector[gesb_pkg::EXT_LOW_BIT +: 4] = extPrevValid ? (extSync ^ extPrev) : 4'h0;
    setVector[gesb_pkg::USB_BIT] = usbSync;
    setVector[gesb_pkg::OVERRIDE_BIT] = overrideEvent;
    setVector[gesb_pkg::THERMAL_BIT] = alarmActive;
  end

  // APB: one wait state, answer registered
  assign accessStart = psel && penable && !pready;
  assign accessDone = psel && penable && pready;
  assign writeDone = accessDone && pwrite;
  assign readDone = accessDone && !pwrite;
  assign statusWrite = writeDone && paddr == gesb_pkg::STATUS_ADDR;
  assign enableWrite = writeDone && paddr == gesb_pkg::ENABLE_ADDR;
  assign configWrite = writeDone && paddr == gesb_pkg::CONFIG_ADDR;
  assign maskWrite = writeDone && paddr == gesb_pkg::IRQ_MASK_ADDR;
  assign irqStatusRead = readDone && paddr == gesb_pkg::IRQ_STATUS_ADDR;

  always_comb begin
    addrMapped = 1'b1;
    readValue = 16'h0000;
    unique case (paddr)
      gesb_pkg::STATUS_ADDR: readValue = eventStatusZero & gesb_pkg::IMPLEMENTED_MASK;
      gesb_pkg::ENABLE_ADDR: readValue = eventEnableZero;
      gesb_pkg::CONFIG_ADDR: readValue = {10'h000, cfgReg};
      gesb_pkg::IRQ_STATUS_ADDR: readValue = irqStatus;
      gesb_pkg::IRQ_MASK_ADDR: readValue = irqMask;
      default: addrMapped = 1'b0;
    endcase
  end

  // ready pulse, one cycle after the access phase opens
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= accessStart;
    end
  end

  // read data stands only with ready
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (accessStart && !pwrite) begin
      prdata <= {16'h0000, readValue};
    end else begin
      prdata <= 32'h0;
    end
  end

  // unmapped addresses answer with an error
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= accessStart && !addrMapped;
    end
  end

  // write-one-to-clear with set taking priority
  assign clearVector = statusWrite ? pwdata[15:0] : 16'h0000;
  assign next_status = ((eventStatusZero & ~clearVector) | setVector) &
    gesb_pkg::IMPLEMENTED_MASK;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      eventStatusZero <= gesb_pkg::STATUS_RESET;
    end else begin
      eventStatusZero <= next_status;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      eventEnableZero <= gesb_pkg::ENABLE_RESET;
    end else if (enableWrite) begin
      eventEnableZero <= pwdata[15:0] & gesb_pkg::IMPLEMENTED_MASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfgReg <= gesb_pkg::CONFIG_RESET;
    end else if (configWrite) begin
      cfgReg <= pwdata[5:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irqMask <= gesb_pkg::IRQ_MASK_RESET;
    end else if (maskWrite) begin
      irqMask <= pwdata[15:0] & gesb_pkg::IMPLEMENTED_MASK;
    end
  end

  // sticky copy of flag rises, cleared by reading it; a rise wins
  assign flagRise = next_status & ~eventStatusZero;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irqStatus <= 16'h0000;
    end else if (irqStatusRead) begin
      irqStatus <= flagRise;
    end else begin
      irqStatus <= irqStatus | flagRise;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus & irqMask);
    end
  end

  // any set flag whose enable bit is one
  assign anyEnabled = |(eventStatusZero & eventEnableZero);

  // control route when the select bit is one
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      controlInterrupt <= 1'b0;
    end else begin
      controlInterrupt <= routeControl && anyEnabled;
    end
  end

  // management route when the select bit is zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      managementInterrupt <= 1'b0;
    end else begin
      managementInterrupt <= !routeControl && anyEnabled;
    end
  end

  // cycles within one throttle slot
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      slotCount <= 32'h0;
    end else if (!alarmQualified) begin
      slotCount <= 32'h0;
    end else if (slotCount >= 32'(SLOT_CYCLES - 1)) begin
      slotCount <= 32'h0;
    end else begin
      slotCount <= slotCount + 32'h1;
    end
  end

  // throttle period: eight slots of SLOT_CYCLES each
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      slotIndex <= 3'h0;
    end else if (!alarmQualified) begin
      slotIndex <= 3'h0;
    end else if (slotCount >= 32'(SLOT_CYCLES - 1)) begin
      slotIndex <= slotIndex + 3'h1;
    end
  end

  // throttle state follows the qualified alarm
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      throttling <= 1'b0;
    end else begin
      throttling <= alarmQualified;
    end
  end

  // duty of zero is reserved and leaves the clock running
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cpuClockRun <= 1'b1;
    end else begin
      cpuClockRun <= !alarmQualified || duty == 3'h0 || slotIndex < duty;
    end
  end

endmodule : gesb_event_status_bank

// ---- verification/gesb_checker_assertions.sv ----
// port-level checker for the event status bank
`timescale 1ns/1ps
module gesb_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic controlInterrupt,
  input wire logic managementInterrupt,
  input wire logic cpuClockRun,
  input wire logic throttling
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_WAIT: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("no answer after one wait state");
  AST_PULSE: assert property (pready |=> !pready) else $error("ready held too long");
  AST_ERRRDY: assert property (pslverr |-> pready) else $error("error without ready");
  AST_IDLE: assert property (!(psel && penable) |-> !pready) else $error("ready outside access");
  AST_UPPER: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  AST_RSV: assert property (pready && !pwrite && paddr == gesb_pkg::STATUS_ADDR |->
    (prdata[15:0] & ~gesb_pkg::IMPLEMENTED_MASK) == 16'h0000) else $error("reserved bit read");
  AST_SEL: assert property (!(controlInterrupt && managementInterrupt))
    else $error("both interrupt routes high");
  AST_RUN: assert property (!throttling && !$past(throttling) |-> cpuClockRun)
    else $error("clock stopped without throttling");
  cover property (pslverr);
  cover property (throttling);
  cover property (controlInterrupt);
endmodule : gesb_checker

// ---- verification/gesb_pin_model.sv ----
// event source pins around the bank, idle unless flipped
`timescale 1ns/1ps
module gesb_pin_model (
  input wire logic [8:0] flip,
  output logic ringIndicatorN,
  output logic acPowerPresent,
  output logic dockingInsertN,
  output logic extInputD,
  output logic extInputC,
  output logic extInputB,
  output logic extInputA,
  output logic usbWake,
  output logic thermalAlarmN
);
  // low-active pins idle high
  assign {ringIndicatorN, acPowerPresent, dockingInsertN, extInputD, extInputC, extInputB,
    extInputA, usbWake, thermalAlarmN} = 9'h141 ^ flip;
endmodule : gesb_pin_model

// ---- verification/tb_top.sv ----
// self-checking bench for the event status bank
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, err, controlInterrupt, managementInterrupt, cpuClockRun, throttling, irq;
  logic ringIndicatorN, acPowerPresent, dockingInsertN, extInputA, extInputB, extInputC;
  logic extInputD, usbWake, thermalAlarmN;
  logic [8:0] flip = 9'h000;
  logic [3:0] pos [9] = '{4'h0, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hA, 4'hB};
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  gesb_event_status_bank #(.ALARM_CYCLES(20), .SLOT_CYCLES(4)) gesb_event_status_bank_inst (.*);
  gesb_pin_model gesb_pin_model_inst (.*);
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic summarize();
    if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk) penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : xfer
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  task automatic t_reset_and_enable();
    rd(gesb_pkg::STATUS_ADDR, 32'h0);
    rd(gesb_pkg::ENABLE_ADDR, 32'h0);
    xfer(1'b1, gesb_pkg::ENABLE_ADDR, 32'h0000FFFF);
    rd(gesb_pkg::ENABLE_ADDR, 32'h00000DF7);
    xfer(1'b0, 8'h40, 32'h0);
    chk({q[31:1], err}, 32'h1);
  endtask : t_reset_and_enable
  task automatic t_events();
    for (int i = 0; i < 9; i++) begin
      flip <= 9'h001 << i;
      repeat (2) @(posedge ref_clk);
      flip <= 9'h000;
      repeat (6) @(posedge ref_clk);
      xfer(1'b1, gesb_pkg::STATUS_ADDR, 32'h0);
      rd(gesb_pkg::STATUS_ADDR, 32'h1 << pos[i]);
      chk({31'h0, managementInterrupt}, 32'h1);
      xfer(1'b1, gesb_pkg::STATUS_ADDR, 32'h1 << pos[i]);
      rd(gesb_pkg::STATUS_ADDR, 32'h0);
      chk({31'h0, managementInterrupt}, 32'h0);
    end
  endtask : t_events
  task automatic t_thermal();
    int high = 0;
    xfer(1'b1, gesb_pkg::CONFIG_ADDR, 32'h1);
    repeat (6) @(posedge ref_clk);
    rd(gesb_pkg::STATUS_ADDR, 32'h1);
    xfer(1'b1, gesb_pkg::CONFIG_ADDR, 32'hE);
    xfer(1'b1, gesb_pkg::STATUS_ADDR, 32'h1);
    flip <= 9'h001;
    repeat (30) @(posedge ref_clk);
    chk({31'h0, throttling}, 32'h1);
    repeat (32) begin
      @(posedge ref_clk);
      high += cpuClockRun;
    end
    chk(32'(high), 32'h4);
    rd(gesb_pkg::STATUS_ADDR, 32'h3);
    chk({31'h0, controlInterrupt}, 32'h1);
    flip <= 9'h000;
    xfer(1'b1, gesb_pkg::CONFIG_ADDR, 32'h0);
    xfer(1'b1, gesb_pkg::STATUS_ADDR, 32'h3);
  endtask : t_thermal
  task automatic t_irq();
    xfer(1'b1, gesb_pkg::IRQ_MASK_ADDR, 32'h0800);
    xfer(1'b0, gesb_pkg::IRQ_STATUS_ADDR, 32'h0);
    flip <= 9'h100;
    repeat (8) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    flip <= 9'h000;
    rd(gesb_pkg::IRQ_STATUS_ADDR, 32'h0800);
    @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
  endtask : t_irq
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset_and_enable();
    t_events();
    t_thermal();
    t_irq();
    summarize();
  end
endmodule : tb_top
bind gesb_event_status_bank gesb_checker gesb_checker_inst (.*);
